// ---- common/nvg_cfg.svh ----
// constants of the nonvolatile busy gate and copy command block
// assumes an I2C-style byte engine on the same clock feeding byte events
`ifndef NVG_CFG_SVH
`define NVG_CFG_SVH

// ==========================================
// clock
`define NVG_CLK_KHZ      25000
`define NVG_KHZ_PER_MHZ  1000

// ==========================================
// opcodes and general call codes
`define NVG_OP_NV2V      8'hb8
`define NVG_OP_V2NV      8'h48
`define NVG_GC_SOFT      8'h04
`define NVG_GC_RESET     8'h06

// ==========================================
// pointer values
`define NVG_PTR_TEMP     8'h00
`define NVG_PTR_CFG      8'h01
`define NVG_PTR_TLO      8'h02
`define NVG_PTR_THI      8'h03
`define NVG_PTR_NVCFG    8'h11
`define NVG_PTR_NVTLO    8'h12
`define NVG_PTR_NVTHI    8'h13

// ==========================================
// address byte fields
`define NVG_ID_SENSOR    4'h9
`define NVG_ID_EEPROM    4'ha
`define NVG_ADR_ARA      7'h0c
`define NVG_ADR_GC       7'h00

// ==========================================
// nonvolatile config bit positions and reset values
`define NVG_LOCK_POS     0
`define NVG_LOCKDN_POS   1
`define NVG_RST_CFG      16'h0000
`define NVG_RST_TLO      16'h4b00
`define NVG_RST_THI      16'h5000

`endif

// ---- common/nvg_pkg.sv ----
// types of the nonvolatile busy gate and copy command block
// assumes nvg_cfg.svh for all numeric constants
package nvg_pkg;

  // ==========================================
  // byte position within a transfer
  typedef enum logic [1:0] {
    NVG_POS_ADDR,
    NVG_POS_PTR,
    NVG_POS_HI,
    NVG_POS_LO
  } nvg_pos_e;

  // one event from the serial engine
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       byte_valid;
    nvg_pos_e   pos;
    logic [7:0] data;
  } nvg_bus_s;

  // ==========================================
  // address byte class
  typedef enum logic [2:0] {
    NVG_ADR_SENSOR,
    NVG_ADR_EEPROM,
    NVG_ADR_ARA,
    NVG_ADR_GCALL,
    NVG_ADR_OTHER
  } nvg_adr_e;

  // self-timed jobs
  typedef enum logic [1:0] {
    NVG_JOB_NONE,
    NVG_JOB_NV2V,
    NVG_JOB_V2NV,
    NVG_JOB_PROG
  } nvg_job_e;

  // configuration and limit set
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] tlo;
    logic [15:0] thi;
  } nvg_set_s;

  // ==========================================
  // main block state
  typedef struct packed {
    logic [2:0]  a_meta;
    logic [2:0]  a_pins;
    logic [7:0]  ptr;
    nvg_set_s    vol;
    nvg_set_s    nv;
    logic [7:0]  hi;
    nvg_adr_e    adr;
    logic        boot;
    nvg_job_e    pend;
    nvg_job_e    run;
    logic [1:0]  pend_idx;
    logic [15:0] pend_val;
  } nvg_state_s;

endpackage

// ---- design/nvg_addr_decode.sv ----
// classifies a received address byte against the strapped pins
// assumes synchronised pin values on the same clock
`timescale 1ns/1ps

module nvg_addr_decode (
  // address byte and straps
  input  wire logic [7:0]   data,
  input  wire logic [2:0]   pins,
  // class
  output nvg_pkg::nvg_adr_e cls
);
`include "nvg_cfg.svh"

  function automatic nvg_pkg::nvg_adr_e classify(input logic [7:0] b, input logic [2:0] p);
    if (b[7:4] == `NVG_ID_SENSOR && b[3:1] == p) begin
      return nvg_pkg::NVG_ADR_SENSOR;
    end else if (b[7:4] == `NVG_ID_EEPROM) begin
      return nvg_pkg::NVG_ADR_EEPROM;
    end else if (b[7:1] == `NVG_ADR_ARA) begin
      return nvg_pkg::NVG_ADR_ARA;
    end else if (b[7:1] == `NVG_ADR_GC) begin
      return nvg_pkg::NVG_ADR_GCALL;
    end
    return nvg_pkg::NVG_ADR_OTHER;
  endfunction

  assign cls = classify(data, pins);

endmodule

// ---- design/nvg_timer.sv ----
// self-timed job counter: busy for a loaded number of cycles, then a done pulse
// assumes start only while idle
`timescale 1ns/1ps

module nvg_timer #(
  parameter int unsigned CW = 20
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          ce,
  // control
  input  wire logic          start,
  input  wire logic [CW-1:0] load,
  // status
  output logic               busy,
  output logic               done
);

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
  } nvg_tmr_s;

  nvg_tmr_s s;
  nvg_tmr_s next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cnt = load;
    end else if (s.busy) begin
      next_s.cnt = s.cnt - CW'(1);
      if (s.cnt <= CW'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

endmodule

// ---- design/nvg_gate.sv ----
// busy gating of serial commands and nonvolatile/volatile copy commands
// assumes a byte engine on clk that reports start, stop and each byte,
// and ANDs pass into its own acknowledge decision
`timescale 1ns/1ps

module nvg_gate #(
  parameter int unsigned COPYR_US = 200,
  parameter int unsigned COPYW_US = 20000,
  parameter int unsigned PROG_US  = 20000
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  // strapped address pins
  input  wire logic [2:0]         addr_pins,
  // byte events and the gate answer
  input  wire nvg_pkg::nvg_bus_s  bus,
  output logic                    pass,
  // other nonvolatile work in progress
  input  wire logic               ext_busy,
  // state shown to the engine
  output logic                    nonvolatile_busy_flag,
  output logic [7:0]              ptr,
  output nvg_pkg::nvg_set_s       vol
);
`include "nvg_cfg.svh"

  // ==========================================
  // timing
  function automatic int unsigned us_to_cyc(input int unsigned us);
    int unsigned c;
    c = us * (`NVG_CLK_KHZ / `NVG_KHZ_PER_MHZ);
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CYC_R = us_to_cyc(COPYR_US);
  localparam int unsigned CYC_W = us_to_cyc(COPYW_US);
  localparam int unsigned CYC_P = us_to_cyc(PROG_US);
  localparam int unsigned CYC_M = (CYC_W > CYC_P) ? ((CYC_W > CYC_R) ? CYC_W : CYC_R)
                                                   : ((CYC_P > CYC_R) ? CYC_P : CYC_R);
  localparam int unsigned CW    = $clog2(CYC_M + 1);

  // ==========================================
  // helpers
  function automatic nvg_pkg::nvg_set_s set_put(input nvg_pkg::nvg_set_s st,
                                                input logic [1:0] idx,
                                                input logic [15:0] v);
    nvg_pkg::nvg_set_s r;
    r = st;
    unique case (idx)
      2'h1: r.cfg = v;
      2'h2: r.tlo = v;
      2'h3: r.thi = v;
      default: r = st;
    endcase
    return r;
  endfunction

  function automatic logic is_vol(input logic [7:0] p);
    return p == `NVG_PTR_CFG || p == `NVG_PTR_TLO || p == `NVG_PTR_THI;
  endfunction

  function automatic logic is_nv(input logic [7:0] p);
    return p == `NVG_PTR_NVCFG || p == `NVG_PTR_NVTLO || p == `NVG_PTR_NVTHI;
  endfunction

  function automatic logic [CW-1:0] job_cyc(input nvg_pkg::nvg_job_e j);
    unique case (j)
      nvg_pkg::NVG_JOB_NV2V: return CW'(CYC_R);
      nvg_pkg::NVG_JOB_V2NV: return CW'(CYC_W);
      default:               return CW'(CYC_P);
    endcase
  endfunction

  // ==========================================
  // state
  nvg_pkg::nvg_state_s s;
  nvg_pkg::nvg_state_s next_s;
  nvg_pkg::nvg_adr_e   adr_cls;
  logic                tmr_start;
  logic [CW-1:0]       tmr_load;
  logic                tmr_busy;
  logic                tmr_done;
  logic                busy;
  logic                copy_r_busy;
  logic                register_lock_bit;
  logic                permanent_lockdown_bit;
  logic                locked;
  logic                opcode;
  nvg_pkg::nvg_job_e   op_job;
  logic [15:0]         wval;

  nvg_addr_decode u_dec (
    .data (bus.data),
    .pins (s.a_pins),
    .cls  (adr_cls)
  );

  nvg_timer #(
    .CW (CW)
  ) u_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  assign busy                   = tmr_busy | tmr_done | ext_busy;
  assign copy_r_busy            = (tmr_busy | tmr_done) && s.run == nvg_pkg::NVG_JOB_NV2V;
  assign register_lock_bit      = s.nv.cfg[`NVG_LOCK_POS];
  assign permanent_lockdown_bit = s.nv.cfg[`NVG_LOCKDN_POS];
  assign locked                 = register_lock_bit | permanent_lockdown_bit;
  assign opcode                 = bus.data == `NVG_OP_NV2V || bus.data == `NVG_OP_V2NV;
  assign op_job                 = (bus.data == `NVG_OP_NV2V) ? nvg_pkg::NVG_JOB_NV2V
                                                              : nvg_pkg::NVG_JOB_V2NV;
  assign wval                   = {s.hi, bus.data};

  // ==========================================
  // command decode and gating
  always_comb begin
    next_s = s;
    pass = 1'b1;
    tmr_start = 1'b0;
    tmr_load = job_cyc(nvg_pkg::NVG_JOB_NV2V);
    next_s.a_meta = addr_pins;
    next_s.a_pins = s.a_meta;
    if (s.boot) begin
      next_s.boot = 1'b0;
      next_s.run = nvg_pkg::NVG_JOB_NV2V;
      tmr_start = 1'b1;
    end
    if (tmr_done) begin
      unique case (s.run)
        nvg_pkg::NVG_JOB_NV2V: next_s.vol = s.nv;
        nvg_pkg::NVG_JOB_V2NV: next_s.nv = s.vol;
        nvg_pkg::NVG_JOB_PROG: next_s.nv = set_put(s.nv, s.pend_idx, s.pend_val);
        nvg_pkg::NVG_JOB_NONE: next_s.nv = s.nv;
      endcase
      next_s.run = nvg_pkg::NVG_JOB_NONE;
    end
    if (bus.start) begin
      next_s.pend = nvg_pkg::NVG_JOB_NONE;
      next_s.adr = nvg_pkg::NVG_ADR_OTHER;
    end
    if (bus.stop) begin
      if (s.pend != nvg_pkg::NVG_JOB_NONE && !busy) begin
        next_s.run = s.pend;
        tmr_start = 1'b1;
        tmr_load = job_cyc(s.pend);
      end
      next_s.pend = nvg_pkg::NVG_JOB_NONE;
      next_s.adr = nvg_pkg::NVG_ADR_OTHER;
    end
    if (bus.byte_valid) begin
      unique case (bus.pos)
        nvg_pkg::NVG_POS_ADDR: begin
          next_s.adr = adr_cls;
          unique case (adr_cls)
            nvg_pkg::NVG_ADR_SENSOR: begin
              if (bus.data[0] && busy) begin
                // temperature always readable, volatile set unless reloading
                pass = (s.ptr == `NVG_PTR_TEMP) || (is_vol(s.ptr) && !copy_r_busy);
              end
            end
            nvg_pkg::NVG_ADR_EEPROM: pass = !busy;
            nvg_pkg::NVG_ADR_ARA:    pass = !busy;
            default:                 pass = 1'b1;
          endcase
        end
        nvg_pkg::NVG_POS_PTR: begin
          if (s.adr == nvg_pkg::NVG_ADR_SENSOR) begin
            if (opcode) begin
              pass = !busy;
              if (!busy && !locked) begin
                next_s.pend = op_job;
              end
            end else begin
              next_s.ptr = bus.data;
            end
          end else if (s.adr == nvg_pkg::NVG_ADR_GCALL) begin
            pass = !(busy && (bus.data == `NVG_GC_SOFT || bus.data == `NVG_GC_RESET));
          end
        end
        nvg_pkg::NVG_POS_HI: begin
          if (s.adr == nvg_pkg::NVG_ADR_SENSOR && s.ptr != `NVG_PTR_TEMP) begin
            pass = !busy;
            next_s.hi = bus.data;
          end
        end
        nvg_pkg::NVG_POS_LO: begin
          if (s.adr == nvg_pkg::NVG_ADR_SENSOR && s.ptr != `NVG_PTR_TEMP) begin
            pass = !busy;
            if (!busy && is_vol(s.ptr) && !locked) begin
              next_s.vol = set_put(s.vol, s.ptr[1:0], wval);
            end else if (!busy && is_nv(s.ptr) && !permanent_lockdown_bit) begin
              next_s.pend_idx = s.ptr[1:0];
              if (!register_lock_bit) begin
                next_s.pend_val = wval;
                next_s.pend = nvg_pkg::NVG_JOB_PROG;
              end else if (s.ptr == `NVG_PTR_NVCFG) begin
                // while locked only the lock bit itself may change
                next_s.pend_val = s.nv.cfg;
                next_s.pend_val[`NVG_LOCK_POS] = wval[`NVG_LOCK_POS];
                next_s.pend = nvg_pkg::NVG_JOB_PROG;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{a_meta: 3'h0, a_pins: 3'h0, ptr: `NVG_PTR_TEMP,
             vol: '{cfg: `NVG_RST_CFG, tlo: `NVG_RST_TLO, thi: `NVG_RST_THI},
             nv: '{cfg: `NVG_RST_CFG, tlo: `NVG_RST_TLO, thi: `NVG_RST_THI},
             hi: 8'h00, adr: nvg_pkg::NVG_ADR_OTHER, boot: 1'b1,
             pend: nvg_pkg::NVG_JOB_NONE, run: nvg_pkg::NVG_JOB_NONE,
             pend_idx: 2'h0, pend_val: 16'h0000};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign nonvolatile_busy_flag = busy;
  assign ptr                   = s.ptr;
  assign vol                   = s.vol;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic rd_addr;
  logic ptr_byte;
  assign rd_addr  = bus.byte_valid && bus.pos == nvg_pkg::NVG_POS_ADDR
                    && adr_cls == nvg_pkg::NVG_ADR_SENSOR && bus.data[0];
  assign ptr_byte = ce && bus.byte_valid && bus.pos == nvg_pkg::NVG_POS_PTR
                    && s.adr == nvg_pkg::NVG_ADR_SENSOR && !bus.start && !bus.stop;

  property p_eeprom_busy;
    bus.byte_valid && bus.pos == nvg_pkg::NVG_POS_ADDR
      && adr_cls == nvg_pkg::NVG_ADR_EEPROM && busy |-> !pass;
  endproperty
  a_eeprom_busy: assert property (p_eeprom_busy) else $error("eeprom acked while busy");

  property p_nvcfg_hi;
    bus.byte_valid && bus.pos == nvg_pkg::NVG_POS_HI && s.adr == nvg_pkg::NVG_ADR_SENSOR
      && s.ptr == `NVG_PTR_NVCFG && busy |-> !pass;
  endproperty
  a_nvcfg_hi: assert property (p_nvcfg_hi) else $error("nv config data acked while busy");

  property p_nv_read;
    rd_addr && busy && is_nv(s.ptr) |-> !pass;
  endproperty
  a_nv_read: assert property (p_nv_read) else $error("nv read acked while busy");

  property p_temp_read;
    rd_addr && s.ptr == `NVG_PTR_TEMP |-> pass;
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature read refused");

  property p_copy_vol_read;
    rd_addr && copy_r_busy && is_vol(s.ptr) |-> !pass;
  endproperty
  a_copy_vol_read: assert property (p_copy_vol_read) else $error("vol read during reload");

  property p_op_keeps_ptr;
    ptr_byte && opcode |=> s.ptr == $past(s.ptr);
  endproperty
  a_op_keeps_ptr: assert property (p_op_keeps_ptr) else $error("opcode changed pointer");

  property p_op_pend;
    ptr_byte && bus.data == `NVG_OP_NV2V && !busy && !locked
      |=> s.pend == nvg_pkg::NVG_JOB_NV2V;
  endproperty
  a_op_pend: assert property (p_op_pend) else $error("reload opcode not taken");

  property p_reload;
    ce && tmr_done && s.run == nvg_pkg::NVG_JOB_NV2V |=> s.vol == $past(s.nv);
  endproperty
  a_reload: assert property (p_reload) else $error("volatile set not reloaded");

  property p_stop_starts;
    ce && bus.stop && s.pend != nvg_pkg::NVG_JOB_NONE && !busy
      |=> tmr_busy && s.run == $past(s.pend);
  endproperty
  a_stop_starts: assert property (p_stop_starts) else $error("copy not started at stop");

  property p_abort;
    ce && bus.start |=> s.pend == nvg_pkg::NVG_JOB_NONE;
  endproperty
  a_abort: assert property (p_abort) else $error("pending copy survived start");

  property p_locked_ign;
    ptr_byte && opcode && locked && !busy |-> pass ##1 s.pend == $past(s.pend);
  endproperty
  a_locked_ign: assert property (p_locked_ign) else $error("locked copy not ignored");

  property p_store;
    ce && tmr_done && s.run == nvg_pkg::NVG_JOB_V2NV |=> s.nv == $past(s.vol);
  endproperty
  a_store: assert property (p_store) else $error("nv set not programmed");

  property p_clear;
    ce && tmr_done && !ext_busy |=> s.run == nvg_pkg::NVG_JOB_NONE && !tmr_done;
  endproperty
  a_clear: assert property (p_clear) else $error("job did not end");

  c_reload: cover property (ce && tmr_done && s.run == nvg_pkg::NVG_JOB_NV2V);
  c_store:  cover property (ce && tmr_done && s.run == nvg_pkg::NVG_JOB_V2NV);
  c_abort:  cover property (ce && bus.start && s.pend != nvg_pkg::NVG_JOB_NONE);
  c_refuse: cover property (bus.byte_valid && !pass);

endmodule

// ---- sim/nvg_master.sv ----
// bus master stand-in that hands byte events to the gate, one per cycle
// assumes the gate takes events on the rising clk and answers pass at once
`timescale 1ns/1ps

module nvg_master (
  // clock
  input  wire logic         clk,
  // gate answer and events
  input  wire logic         pass,
  output nvg_pkg::nvg_bus_s bus
);
  // ==========================================
  // event driving
  initial bus = '0;

  task automatic put(input logic s, input logic p, input logic v,
                     input logic [1:0] pos, input logic [7:0] d);
    bus <= {s, p, v, pos, d};
  endtask

  // released data always inverts the data of the event before it
  task automatic idle();
    put(1'b0, 1'b0, 1'b0, 2'h0, ~bus.data);
    @(posedge clk);
  endtask

  // start, n bytes in order, then stop; gives up after a nack
  task automatic xfer(input int n, input logic [0:3][7:0] b, input logic rs,
                      output logic [0:3] acks);
    acks = '0;
    put(1'b1, 1'b0, 1'b0, 2'h0, ~bus.data);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      put(1'b0, 1'b0, 1'b1, i[1:0], b[i]);
      @(posedge clk);
      acks[i] = pass;
      if (pass !== 1'b1) break;
    end
    if (rs) begin
      put(1'b1, 1'b0, 1'b0, 2'h0, ~bus.data);
      @(posedge clk);
    end
    put(1'b0, 1'b1, 1'b0, 2'h0, ~bus.data);
    @(posedge clk);
    idle();
  endtask
endmodule

// ---- sim/nvg_gate_tb.sv ----
// self-checking bench of the busy gate and copy commands
// assumes nvg_master as the far side and short self-timed jobs
`timescale 1ns/1ps
`include "nvg_cfg.svh"

module nvg_gate_tb;
  // ==========================================
  // setup
  localparam int         CYC_R = 25;
  localparam int         CYC_W = 50;
  localparam int         LIMIT = 5000;
  localparam logic [2:0] PINS  = 3'h5;
  localparam logic [7:0] SW    = {4'h9, PINS, 1'b0};
  localparam logic [7:0] SR    = {4'h9, PINS, 1'b1};

  typedef struct packed {
    logic            ext;
    logic [2:0]      n;
    logic [0:3][7:0] b;
    logic [0:3]      acks;
    logic [7:0]      ptr;
  } nvg_row_s;

  logic              clk;
  logic              reset_n;
  logic              ce;
  logic              ext;
  logic [2:0]        pins;
  logic              pass;
  logic              nvf;
  logic [7:0]        ptr;
  nvg_pkg::nvg_set_s vol;
  nvg_pkg::nvg_bus_s bus;
  nvg_row_s          rows [0:17];
  int                checks;
  int                err_total;
  int                cycles;
  int                n;

  always #20 clk = ~clk;

  nvg_gate #(.COPYR_US(1), .COPYW_US(2), .PROG_US(2)) i_dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr_pins(pins), .bus(bus),
    .pass(pass), .ext_busy(ext), .nonvolatile_busy_flag(nvf), .ptr(ptr),
    .vol(vol));

  nvg_master i_mst (.clk(clk), .pass(pass), .bus(bus));

  // ==========================================
  // compares and closing
  task automatic bad(input string what);
    err_total++;
    $display("BAD %0t %s", $time, what);
  endtask
  task automatic chk_acks(input logic [0:3] got, input logic [0:3] exp);
    checks++;
    if (got !== exp) bad($sformatf("acks %b want %b", got, exp));
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("ptr %h want %h", got, exp));
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("word %h want %h", got, exp));
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) bad($sformatf("flag %b want %b", got, exp));
  endtask
  task automatic chk_set(input logic [15:0] c, input logic [15:0] l, input logic [15:0] h);
    chk_word(vol.cfg, c);
    chk_word(vol.tlo, l);
    chk_word(vol.thi, h);
  endtask
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad("timeout");
      final_report();
    end
  end

  // ==========================================
  // transfers and busy timing
  task automatic go(input int k, input logic [0:3][7:0] b, input logic rs,
                    input logic [0:3] exp);
    logic [0:3] got;
    i_mst.xfer(k, b, rs, got);
    chk_acks(got, exp);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    go(4, {SW, p, v[15:8], v[7:0]}, 1'b0, 4'b1111);
  endtask
  task automatic wait_lvl(input logic lvl, input int max);
    n = 0;
    while (nvf !== lvl && n < max) begin
      @(posedge clk);
      n++;
    end
    chk_flag(nvf, lvl);
  endtask
  task automatic expect_busy(input int min);
    wait_lvl(1'b1, 4);
    wait_lvl(1'b0, min + 8);
    chk_flag(n >= min && n <= min + 2, 1'b1);
  endtask
  task automatic no_busy();
    repeat (8) begin
      @(posedge clk);
      chk_flag(nvf, 1'b0);
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    ext = 1'b0;
    pins = PINS;
    checks = 0;
    err_total = 0;
    cycles = 0;
    rows = '{
      {1'b1, 3'd2, SW, 8'h00, 8'h00, 8'h00, 4'b1100, 8'h00},
      {1'b1, 3'd1, SR, 8'h00, 8'h00, 8'h00, 4'b1000, 8'h00},
      {1'b1, 3'd2, SW, 8'h01, 8'h00, 8'h00, 4'b1100, 8'h01},
      {1'b1, 3'd1, SR, 8'h00, 8'h00, 8'h00, 4'b1000, 8'h01},
      {1'b1, 3'd2, SW, 8'h03, 8'h00, 8'h00, 4'b1100, 8'h03},
      {1'b1, 3'd1, SR, 8'h00, 8'h00, 8'h00, 4'b1000, 8'h03},
      {1'b1, 3'd4, SW, 8'h01, 8'h00, 8'h00, 4'b1100, 8'h01},
      {1'b1, 3'd4, SW, 8'h11, 8'h00, 8'h00, 4'b1100, 8'h11},
      {1'b1, 3'd1, SR, 8'h00, 8'h00, 8'h00, 4'b0000, 8'h11},
      {1'b1, 3'd2, SW, 8'hb8, 8'h00, 8'h00, 4'b1000, 8'h11},
      {1'b1, 3'd2, SW, 8'h48, 8'h00, 8'h00, 4'b1000, 8'h11},
      {1'b1, 3'd2, 8'ha0, 8'h00, 8'h00, 8'h00, 4'b0000, 8'h11},
      {1'b1, 3'd1, 8'h19, 8'h00, 8'h00, 8'h00, 4'b0000, 8'h11},
      {1'b1, 3'd2, 8'h00, 8'h04, 8'h00, 8'h00, 4'b1000, 8'h11},
      {1'b1, 3'd2, 8'h00, 8'h06, 8'h00, 8'h00, 4'b1000, 8'h11},
      {1'b0, 3'd1, SR, 8'h00, 8'h00, 8'h00, 4'b1000, 8'h11},
      {1'b0, 3'd2, 8'ha0, 8'h00, 8'h00, 8'h00, 4'b1100, 8'h11},
      {1'b0, 3'd2, SW, 8'h12, 8'h00, 8'h00, 4'b1100, 8'h12}};
    repeat (4) @(posedge clk);
    chk_byte(ptr, 8'h00);
    chk_set(`NVG_RST_CFG, `NVG_RST_TLO, `NVG_RST_THI);
    @(posedge clk);
    reset_n <= 1'b1;
    expect_busy(CYC_R);
    chk_set(`NVG_RST_CFG, `NVG_RST_TLO, `NVG_RST_THI);
    foreach (rows[i]) begin
      ext <= rows[i].ext;
      go(rows[i].n, rows[i].b, 1'b0, rows[i].acks);
      chk_byte(ptr, rows[i].ptr);
    end
    ext <= 1'b0;
    // volatile set, then copy it to the nonvolatile side
    wr(8'h01, 16'h00a0);
    wr(8'h02, 16'h1234);
    wr(8'h03, 16'h5678);
    go(2, {SW, 8'h48, 16'h0000}, 1'b0, 4'b1100);
    expect_busy(CYC_W);
    // repeated start drops the pending copy
    wr(8'h02, 16'h1111);
    go(2, {SW, 8'hb8, 16'h0000}, 1'b1, 4'b1100);
    no_busy();
    chk_word(vol.tlo, 16'h1111);
    // copy back, reads of volatile limits refused meanwhile
    go(2, {SW, 8'h02, 16'h0000}, 1'b0, 4'b1100);
    go(2, {SW, 8'hb8, 16'h0000}, 1'b0, 4'b1100);
    wait_lvl(1'b1, 4);
    go(1, {SR, 24'h000000}, 1'b0, 4'b0000);
    wait_lvl(1'b0, CYC_R + 8);
    chk_set(16'h00a0, 16'h1234, 16'h5678);
    // lock, then lockdown: copies acked and ignored
    wr(8'h11, 16'h0001);
    expect_busy(CYC_W);
    wr(8'h02, 16'h2222);
    chk_word(vol.tlo, 16'h1234);
    go(2, {SW, 8'h48, 16'h0000}, 1'b0, 4'b1100);
    no_busy();
    go(2, {SW, 8'hb8, 16'h0000}, 1'b0, 4'b1100);
    no_busy();
    wr(8'h11, 16'h0000);
    expect_busy(CYC_W);
    wr(8'h11, 16'h0002);
    expect_busy(CYC_W);
    go(2, {SW, 8'hb8, 16'h0000}, 1'b0, 4'b1100);
    no_busy();
    // mid-run reset reloads; clock enable low freezes the reload
    reset_n <= 1'b0;
    @(posedge clk);
    chk_byte(ptr, 8'h00);
    chk_flag(nvf, 1'b0);
    reset_n <= 1'b1;
    wait_lvl(1'b1, 4);
    ce <= 1'b0;
    repeat (CYC_R + 8) @(posedge clk);
    chk_flag(nvf, 1'b1);
    ce <= 1'b1;
    wait_lvl(1'b0, CYC_R + 8);
    chk_set(`NVG_RST_CFG, `NVG_RST_TLO, `NVG_RST_THI);
    final_report();
  end
endmodule
